// [core/ifdpc_core.sv]
// inverter frequency and duty control core with avalon register slave
//
// Our own choices: the address map and the Avalon-MM register port.
`timescale 1ns/1ns
`default_nettype none
module ifdpc_core import ifdpc_pkg::*; (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [15:0] meas_current,
  input wire logic meas_valid,
  output logic drive_a,
  output logic drive_b
);
  ifdpc_link_if link ();

  ifdpc_pid u_pid (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .link(link.pid)
  );

  ifdpc_pwm u_pwm (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .link(link.pwm)
  );

  // ==========================================================
  // register slave state
  logic [31:0] readdata;
  logic [31:0] next_readdata;
  logic waitreq;
  logic next_waitreq;
  logic enable;
  logic next_enable;
  // ping is a one-cycle strobe and never reads back
  logic ping_req;
  logic next_ping_req;
  logic [15:0] target;
  logic [15:0] next_target;
  logic wr_take;

  // ==========================================================
  // control state
  ifdpc_state_type state;
  ifdpc_state_type next_state;
  ifdpc_freq_type freq;
  ifdpc_freq_type next_freq;
  ifdpc_duty_type duty;
  ifdpc_duty_type next_duty;
  logic [15:0] meas;
  logic [15:0] next_meas;
  ifdpc_err_type error;
  ifdpc_err_type next_error;
  logic pid_start;
  logic next_pid_start;
  logic pid_clear;
  logic next_pid_clear;
  logic run;
  logic next_run;

  // ==========================================================
  // avalon slave: waitrequest drops for one cycle, one cycle after a request
  // one wait state keeps read data a plain register, at two cycles per access
  assign wr_take = avs_write && !waitreq;

  always_comb begin
    next_waitreq = 1'b1;
    if ((avs_read || avs_write) && waitreq) begin
      next_waitreq = 1'b0;
    end
    next_readdata = readdata;
    next_enable = enable;
    next_target = target;
    next_ping_req = 1'b0;
    // ==========================================================
    // readback, captured while waitrequest is still high
    if (avs_read && waitreq) begin
      case (avs_address)
        ADDR_CTRL: begin
          next_readdata = 32'(enable) << CTRL_ENABLE_BIT;
        end
        ADDR_STATUS: begin
          next_readdata = (32'(state != st_off) << STATUS_RUN_BIT)
            | (32'(state == st_duty) << STATUS_DUTY_BIT);
        end
        ADDR_TARGET: begin
          next_readdata = 32'(target);
        end
        ADDR_FREQ: begin
          next_readdata = 32'(freq);
        end
        ADDR_DUTY: begin
          next_readdata = 32'(duty);
        end
        ADDR_CURRENT: begin
          next_readdata = 32'(meas);
        end
        default: begin
          next_readdata = 32'h00000000;
        end
      endcase
    end

    // ==========================================================
    // register writes land at the edge that answers them
    if (wr_take) begin
      case (avs_address)
        ADDR_CTRL: begin
          if (avs_byteenable[0]) begin
            next_enable = avs_writedata[CTRL_ENABLE_BIT];
            next_ping_req = avs_writedata[CTRL_PING_BIT];
          end
        end
        ADDR_TARGET: begin
          if (avs_byteenable[0]) begin
            next_target[7:0] = avs_writedata[7:0];
          end
          if (avs_byteenable[1]) begin
            next_target[15:8] = avs_writedata[15:8];
          end
        end
        default: begin
          next_target = target;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      waitreq <= 1'b1;
      readdata <= 32'h00000000;
      enable <= 1'b0;
      ping_req <= 1'b0;
      target <= TARGET_RESET;
    end else begin
      waitreq <= next_waitreq;
      readdata <= next_readdata;
      enable <= next_enable;
      ping_req <= next_ping_req;
      target <= next_target;
    end
  end

  // ==========================================================
  // power control: sample, run the loop, apply one correction per sample
  always_comb begin
    logic [3:0] f_step;
    logic signed [21:0] f_delta;
    logic signed [22:0] f_cand;
    logic signed [17:0] d_cand;
    f_step = STEP_BAND3;
    f_delta = 22'sd0;
    f_cand = 23'sd0;
    d_cand = 18'sd0;
    next_state = state;
    next_freq = freq;
    next_duty = duty;
    next_meas = meas;
    next_error = error;
    next_pid_start = 1'b0;
    next_pid_clear = 1'b0;
    if (meas_valid) begin
      next_meas = meas_current;
    end
    if (freq < FREQ_BAND1) begin
      f_step = STEP_BAND0;
    end else if (freq < FREQ_BAND2) begin
      f_step = STEP_BAND1;
    end else if (freq < FREQ_BAND3) begin
      f_step = STEP_BAND2;
    end
    // positive loop output means too much power
    f_delta = 22'(link.pid_out * $signed({1'b0, f_step}));
    f_cand = $signed({4'h0, freq}) + 23'(f_delta);
    d_cand = $signed({5'h00, duty}) - 18'(link.pid_out);

    // ==========================================================
    // mode decisions; integral carries over a mode switch so the handover is smooth
    case (state)
      st_off: begin
        if (enable && ping_req) begin
          next_state = st_freq;
          next_freq = FREQ_PING;
          next_duty = DUTY_MAX;
          next_pid_clear = 1'b1;
        end
      end
      st_freq, st_duty: begin
        // dropping enable stops the bridge at once, even mid correction
        if (!enable) begin
          next_state = st_off;
        end else if (ping_req) begin
          // a ping while running starts over from the ping point
          next_state = st_freq;
          next_freq = FREQ_PING;
          next_duty = DUTY_MAX;
          next_pid_clear = 1'b1;
        end else begin
          if (meas_valid) begin
            next_error = 17'($signed({1'b0, meas_current}) - $signed({1'b0, target}));
            next_pid_start = 1'b1;
          end
          if (link.pid_done && state == st_freq) begin
            if (freq == FREQ_MAX && link.pid_out > 16'sh0000) begin
              next_state = st_duty;
              if (d_cand < $signed({5'h00, DUTY_MIN})) begin
                next_duty = DUTY_MIN;
              end else begin
                next_duty = 13'(d_cand);
              end
            end else if (f_cand > $signed({4'h0, FREQ_MAX})) begin
              next_freq = FREQ_MAX;
            end else if (f_cand < $signed({4'h0, FREQ_MIN})) begin
              next_freq = FREQ_MIN;
            end else begin
              next_freq = 19'(f_cand);
            end
          end else if (link.pid_done) begin
            if (d_cand >= $signed({5'h00, DUTY_MAX})) begin
              next_duty = DUTY_MAX;
              next_state = st_freq;
            end else if (d_cand < $signed({5'h00, DUTY_MIN})) begin
              next_duty = DUTY_MIN;
            end else begin
              next_duty = 13'(d_cand);
            end
          end
        end
      end
      default: begin
        next_state = st_off;
      end
    endcase

    // ==========================================================
    // duty below half only ever stands at the top frequency
    if (next_state != st_duty) begin
      next_duty = DUTY_MAX;
    end else begin
      next_freq = FREQ_MAX;
    end
    next_run = (next_state != st_off);
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state <= st_off;
      freq <= FREQ_PING;
      duty <= DUTY_MAX;
      meas <= 16'h0000;
      error <= 17'sh00000;
      pid_start <= 1'b0;
      pid_clear <= 1'b0;
      run <= 1'b0;
    end else begin
      state <= next_state;
      freq <= next_freq;
      duty <= next_duty;
      meas <= next_meas;
      error <= next_error;
      pid_start <= next_pid_start;
      pid_clear <= next_pid_clear;
      run <= next_run;
    end
  end

  // ==========================================================
  // links to the loop filter and the drive generator
  assign link.pid_start = pid_start;
  assign link.pid_clear = pid_clear;
  assign link.pid_error = error;
  assign link.pwm_run = run;
  assign link.pwm_freq = freq;
  assign link.pwm_duty = duty;
  // drives come straight from the generator's flip-flops
  assign drive_a = link.drive_a;
  assign drive_b = link.drive_b;
  assign avs_readdata = readdata;
  assign avs_waitrequest = waitreq;
endmodule
`default_nettype wire

// [core/ifdpc_pkg.sv]
// shared constants and types for the inverter frequency and duty control core
`default_nettype none
package ifdpc_pkg;
  // ==========================================================
  // clock
  localparam int CLK_HZ = 50000000;

  // ==========================================================
  // register map, byte offsets
  localparam logic [4:0] ADDR_CTRL = 5'h00;
  localparam logic [4:0] ADDR_STATUS = 5'h04;
  localparam logic [4:0] ADDR_TARGET = 5'h08;
  localparam logic [4:0] ADDR_FREQ = 5'h0c;
  localparam logic [4:0] ADDR_DUTY = 5'h10;
  localparam logic [4:0] ADDR_CURRENT = 5'h14;
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_PING_BIT = 1;
  localparam int STATUS_RUN_BIT = 0;
  localparam int STATUS_DUTY_BIT = 1;
  localparam logic [15:0] TARGET_RESET = 16'h0000;

  // ==========================================================
  // operating frequency in half-hertz units, duty in 0.01 percent units
  typedef logic [18:0] ifdpc_freq_type;
  typedef logic [12:0] ifdpc_duty_type;
  typedef logic signed [16:0] ifdpc_err_type;
  typedef logic signed [15:0] ifdpc_out_type;
  typedef enum logic [1:0] {st_off, st_freq, st_duty} ifdpc_state_type;

  localparam ifdpc_freq_type FREQ_MIN = 19'd220000;
  localparam ifdpc_freq_type FREQ_MAX = 19'd410000;
  localparam ifdpc_freq_type FREQ_PING = 19'd350000;
  localparam ifdpc_freq_type FREQ_BAND1 = 19'd280000;
  localparam ifdpc_freq_type FREQ_BAND2 = 19'd320000;
  localparam ifdpc_freq_type FREQ_BAND3 = 19'd360000;
  localparam logic [3:0] STEP_BAND0 = 4'h3;
  localparam logic [3:0] STEP_BAND1 = 4'h4;
  localparam logic [3:0] STEP_BAND2 = 4'h6;
  localparam logic [3:0] STEP_BAND3 = 4'ha;
  localparam ifdpc_duty_type DUTY_MAX = 13'd5000;
  localparam ifdpc_duty_type DUTY_MIN = 13'd1000;

  // ==========================================================
  // loop gains; integral is kept in units of one twentieth
  localparam int KP = 10;
  localparam int KI_DIV = 20;
  localparam int LOOP_MS = 1;
  localparam int I_LIMIT = 3000;
  localparam int OUT_LIMIT = 20000;
  localparam int DIV_MUL = (65536 + KI_DIV - 1) / KI_DIV;

  // ==========================================================
  // phase accumulator scaling
  localparam logic [21:0] TUNE_K = 22'((64'd1 << 48) / (64'd2 * 64'(CLK_HZ)));
  localparam logic [18:0] DUTY_K = 19'((64'd1 << 32) / 64'd10000);
endpackage
`default_nettype wire

// [core/ifdpc_link_if.sv]
// links the control core to its loop filter and drive generator
`timescale 1ns/1ns
`default_nettype none
interface ifdpc_link_if;
  import ifdpc_pkg::*;
  logic pid_start;
  logic pid_clear;
  ifdpc_err_type pid_error;
  logic pid_done;
  ifdpc_out_type pid_out;
  logic pwm_run;
  ifdpc_freq_type pwm_freq;
  ifdpc_duty_type pwm_duty;
  logic drive_a;
  logic drive_b;
  modport ctl (output pid_start, pid_clear, pid_error, pwm_run, pwm_freq, pwm_duty,
    input pid_done, pid_out, drive_a, drive_b);
  modport pid (input pid_start, pid_clear, pid_error, output pid_done, pid_out);
  modport pwm (input pwm_run, pwm_freq, pwm_duty, output drive_a, drive_b);
endinterface
`default_nettype wire

// [core/ifdpc_pid.sv]
// proportional-integral loop filter with clamped integral and output
`timescale 1ns/1ns
`default_nettype none
module ifdpc_pid import ifdpc_pkg::*; (
  input wire logic sys_clk,
  input wire logic sys_rst,
  ifdpc_link_if.pid link
);
  logic signed [31:0] integ;
  logic signed [31:0] next_integ;
  ifdpc_out_type out;
  ifdpc_out_type next_out;
  logic done;
  logic next_done;

  // ==========================================================
  // loop arithmetic; derivative gain is zero so no history is kept
  always_comb begin
    logic signed [31:0] e32;
    logic signed [31:0] i_sum;
    logic signed [31:0] o20;
    logic signed [47:0] o_scaled;
    e32 = 32'(link.pid_error);
    i_sum = integ + e32 * 32'(LOOP_MS);
    o20 = 32'sd0;
    o_scaled = 48'sd0;
    next_integ = integ;
    next_out = out;
    next_done = 1'b0;
    if (link.pid_clear) begin
      next_integ = 32'sd0;
      next_out = 16'sh0000;
    end else if (link.pid_start) begin
      if (i_sum > 32'(I_LIMIT * KI_DIV)) begin
        i_sum = 32'(I_LIMIT * KI_DIV);
      end else if (i_sum < -32'(I_LIMIT * KI_DIV)) begin
        i_sum = -32'(I_LIMIT * KI_DIV);
      end
      o20 = e32 * 32'(KP * KI_DIV) + i_sum;
      // multiply-shift stands in for a divide by the integral scale
      o_scaled = (48'(o20) * 48'(DIV_MUL)) >>> 16;
      if (o_scaled > 48'(OUT_LIMIT)) begin
        next_out = 16'(OUT_LIMIT);
      end else if (o_scaled < -48'(OUT_LIMIT)) begin
        next_out = -16'(OUT_LIMIT);
      end else begin
        next_out = 16'(o_scaled);
      end
      next_integ = i_sum;
      next_done = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      integ <= 32'sd0;
      out <= 16'sh0000;
      done <= 1'b0;
    end else begin
      integ <= next_integ;
      out <= next_out;
      done <= next_done;
    end
  end

  assign link.pid_out = out;
  assign link.pid_done = done;
endmodule
`default_nettype wire

// [core/ifdpc_pwm.sv]
// phase accumulator drive generator for the two bridge legs
`timescale 1ns/1ns
`default_nettype none
module ifdpc_pwm import ifdpc_pkg::*; (
  input wire logic sys_clk,
  input wire logic sys_rst,
  ifdpc_link_if.pwm link
);
  logic [31:0] phase;
  logic [31:0] next_phase;
  logic [31:0] tune;
  logic [31:0] next_tune;
  logic [31:0] thr;
  logic [31:0] next_thr;
  logic drv_a;
  logic next_drv_a;
  logic drv_b;
  logic next_drv_b;

  // ==========================================================
  // fractional phase steps give far finer than one-cycle period steps
  always_comb begin
    logic [40:0] prod;
    logic [31:0] phase_b;
    prod = 41'(link.pwm_freq) * 41'(TUNE_K);
    phase_b = {~phase[31], phase[30:0]};
    next_tune = 32'(prod[40:16]);
    next_thr = 32'(link.pwm_duty) * 32'(DUTY_K);
    next_phase = link.pwm_run ? phase + tune : 32'h00000000;
    // leg b is leg a shifted half a period, so the bridge stays balanced
    next_drv_a = link.pwm_run && (phase < thr);
    next_drv_b = link.pwm_run && (phase_b < thr);
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      phase <= 32'h00000000;
      tune <= 32'h00000000;
      thr <= 32'h00000000;
      drv_a <= 1'b0;
      drv_b <= 1'b0;
    end else begin
      phase <= next_phase;
      tune <= next_tune;
      thr <= next_thr;
      drv_a <= next_drv_a;
      drv_b <= next_drv_b;
    end
  end

  assign link.drive_a = drv_a;
  assign link.drive_b = drv_b;
endmodule
`default_nettype wire

// [tb/ifdpc_bridge_model.sv]
// bridge and coil stand-in: times the leg a waveform and counts cycles with both legs on
`timescale 1ns/1ns
`default_nettype none
module ifdpc_bridge_model (
  input wire logic sys_clk,
  input wire logic drive_a,
  input wire logic drive_b,
  output int period,
  output int high_time,
  output int overlap
);
  // two-state counters start at zero, so only the clocked process drives them
  int pc;
  int hc;
  bit a_q;
  // ==========================================================
  // timing in clock cycles
  always @(posedge sys_clk) begin
    // both legs on would short the supply rail
    if (drive_a && drive_b) begin
      overlap <= overlap + 1;
    end
    pc <= pc + 1;
    if (drive_a) begin
      hc <= hc + 1;
    end
    if (drive_a && !a_q) begin
      period <= pc;
      pc <= 1;
    end
    if (!drive_a && a_q) begin
      high_time <= hc;
      hc <= 0;
    end
    a_q <= drive_a;
  end
endmodule
`default_nettype wire

// [tb/ifdpc_core_asserts.sv]
// port checker for the inverter control core
`timescale 1ns/1ns
`default_nettype none
module ifdpc_core_asserts import ifdpc_pkg::*; (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [15:0] meas_current,
  input wire logic meas_valid,
  input wire logic drive_a,
  input wire logic drive_b
);
  // ==========================================================
  // helper state: enable copy and leg timing
  logic a_q;
  logic en;
  logic next_en;
  logic wr_ctrl;
  logic [9:0] pc;
  logic [9:0] hc;
  logic [9:0] next_pc;
  logic [9:0] next_hc;
  assign wr_ctrl = avs_write && !avs_waitrequest && avs_address == ADDR_CTRL && avs_byteenable[0];
  always_comb begin
    next_en = wr_ctrl ? avs_writedata[CTRL_ENABLE_BIT] : en;
    next_pc = (pc == 10'h3ff) ? pc : pc + 10'h001;
    // restart timing after a stop so a cut-short cycle is not judged
    if (!en) begin
      next_pc = 10'h3ff;
    end else if (drive_a && !a_q) begin
      next_pc = 10'h001;
    end
    next_hc = drive_a ? hc + 10'h001 : 10'h000;
  end
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      a_q <= 1'b0;
      en <= 1'b0;
      pc <= 10'h3ff;
      hc <= 10'h000;
    end else begin
      a_q <= drive_a;
      en <= next_en;
      pc <= next_pc;
      hc <= next_hc;
    end
  end
  // ==========================================================
  // assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered");
  answer_once_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  rdata_hold_a: assert property (!$stable(avs_readdata) |-> $fell(avs_waitrequest) && $past(avs_read))
    else $error("read data moved outside a read answer");
  reset_off_a: assert property (disable iff (1'b0)
    sys_rst |=> !drive_a && !drive_b && avs_waitrequest && avs_readdata == 32'h0)
    else $error("reset state wrong");
  legs_apart_a: assert property (!(drive_a && drive_b))
    else $error("both legs on");
  period_range_a: assert property (en && drive_a && !a_q && pc != 10'h3ff |->
    pc >= 10'd243 && pc <= 10'd456) else $error("drive period out of range");
  high_range_a: assert property (en && !drive_a && a_q |-> hc >= 10'd24 && hc <= 10'd228)
    else $error("drive high time out of range");
  ping_start_a: assert property (wr_ctrl && avs_writedata[CTRL_ENABLE_BIT]
    && avs_writedata[CTRL_PING_BIT] |-> ##[1:300] drive_a) else $error("ping gave no drive");
  stop_off_a: assert property ($fell(en) |-> ##[0:6] (!drive_a && !drive_b) [*8])
    else $error("drive kept after disable");
endmodule
bind ifdpc_core ifdpc_core_asserts u_chk (
  .sys_clk(sys_clk),
  .sys_rst(sys_rst),
  .avs_address(avs_address),
  .avs_read(avs_read),
  .avs_write(avs_write),
  .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest),
  .meas_current(meas_current),
  .meas_valid(meas_valid),
  .drive_a(drive_a),
  .drive_b(drive_b)
);
`default_nettype wire

// [tb/ifdpc_core_bench.sv]
// self-checking bench for the inverter control core
`timescale 1ns/1ns
`default_nettype none
module ifdpc_core_bench import ifdpc_pkg::*; ();
  logic sys_clk;
  logic sys_rst;
  logic avs_read;
  logic avs_write;
  logic avs_waitrequest;
  logic meas_valid;
  logic drive_a;
  logic drive_b;
  logic [4:0] avs_address;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic [31:0] rd;
  logic [15:0] meas_current;
  logic [15:0] target;
  int n_fail;
  int tests_run;
  int per;
  int high_time;
  int overlap;
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  ifdpc_core dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .meas_current(meas_current),
    .meas_valid(meas_valid), .drive_a(drive_a), .drive_b(drive_b));
  ifdpc_bridge_model bridge (.sys_clk(sys_clk), .drive_a(drive_a), .drive_b(drive_b),
    .period(per), .high_time(high_time), .overlap(overlap));
  // ==========================================================
  // tasks
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one idle cycle first, so a release never meets a new request in one step
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= wd;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0 && n < 20) begin
      n++;
      @(posedge sys_clk);
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n == 20) begin
      n_fail++;
      end_of_test();
    end
  endtask
  task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(rd, exp);
  endtask
  task automatic sample(input int e);
    @(posedge sys_clk);
    meas_current <= 16'(int'(target) + e);
    meas_valid <= 1'b1;
    @(posedge sys_clk);
    meas_valid <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask
  // the period is read after the wait, once the waveform has settled
  task automatic in_rng(input int lo, input int hi);
    repeat (1000) @(posedge sys_clk);
    check(32'(per >= lo && per <= hi), 32'h1);
  endtask
  // ==========================================================
  // sequence
  initial begin
    sys_rst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 5'h00;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    meas_valid = 1'b0;
    meas_current = 16'h0000;
    target = 16'd1000;
    n_fail = 0;
    tests_run = 0;
    repeat (20) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rd_chk(ADDR_FREQ, 32'(FREQ_PING));
    rd_chk(ADDR_DUTY, 32'(DUTY_MAX));
    rd_chk(ADDR_STATUS, 32'h0);
    rd_chk(5'h18, 32'h0);
    rd_chk(ADDR_TARGET, 32'(TARGET_RESET));
    bus(1'b1, ADDR_TARGET, 32'(target));
    rd_chk(ADDR_TARGET, 32'h3e8);
    bus(1'b1, ADDR_CTRL, 32'h3);
    rd_chk(ADDR_STATUS, 32'h1);
    in_rng(285, 286);
    check(32'(high_time >= 142 && high_time <= 143), 32'h1);
    sample(10);
    rd_chk(ADDR_FREQ, 32'd350600);
    rd_chk(ADDR_CURRENT, 32'd1010);
    sample(10);
    rd_chk(ADDR_FREQ, 32'd351206);
    target = 16'd4000;
    bus(1'b1, ADDR_TARGET, 32'(target));
    sample(2000);
    rd_chk(ADDR_FREQ, 32'(FREQ_MAX));
    sample(2000);
    rd_chk(ADDR_DUTY, 32'(DUTY_MIN));
    rd_chk(ADDR_STATUS, 32'h3);
    in_rng(243, 244);
    check(32'(high_time >= 24 && high_time <= 25), 32'h1);
    sample(-3000);
    rd_chk(ADDR_DUTY, 32'(DUTY_MAX));
    rd_chk(ADDR_STATUS, 32'h1);
    sample(-3000);
    rd_chk(ADDR_FREQ, 32'(FREQ_MIN));
    in_rng(454, 455);
    check(32'(high_time >= 227 && high_time <= 228), 32'h1);
    bus(1'b1, ADDR_CTRL, 32'h0);
    sample(2000);
    rd_chk(ADDR_STATUS, 32'h0);
    rd_chk(ADDR_FREQ, 32'(FREQ_MIN));
    bus(1'b1, ADDR_CTRL, 32'h2);
    rd_chk(ADDR_STATUS, 32'h0);
    check(32'(overlap), 32'h0);
    end_of_test();
  end
endmodule
`default_nettype wire
